// ===== hdl/clr_exec_pkg.sv
package clr_exec_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and instruction cycle
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned PHASE_COUNT   = 4;
	localparam int unsigned INSTR_CYCLE_NS = CLK_PERIOD_NS * PHASE_COUNT;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] ADDR_INSTR     = 8'h00;
	localparam logic [7:0] ADDR_WORK      = 8'h04;
	localparam logic [7:0] ADDR_STATUS    = 8'h08;
	localparam logic [7:0] ADDR_FILE_ADDR = 8'h0c;
	localparam logic [7:0] ADDR_FILE_DATA = 8'h10;
	localparam logic [7:0] ADDR_WDOG      = 8'h14;
	localparam logic [7:0] ADDR_WDOG_CFG  = 8'h18;

	////////////////////////////////////////////////////////////////////////////
	// Field positions, widths and file depth
	localparam int unsigned INSTR_W       = 14;
	localparam int unsigned BUSY_BIT      = 16;
	localparam int unsigned UNSUP_BIT     = 17;
	localparam int unsigned STAT_Z_BIT    = 2;
	localparam int unsigned STAT_PD_BIT   = 3;
	localparam int unsigned STAT_TO_BIT   = 4;
	localparam int unsigned WDOG_PRE_LSB  = 8;
	localparam int unsigned FILE_ADDR_W   = 7;
	localparam int unsigned FILE_DEPTH    = 128;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned WDOG_CNT_W    = 8;
	localparam int unsigned WDOG_PRE_W    = 8;

	////////////////////////////////////////////////////////////////////////////
	// Encodings
	localparam logic [6:0]  OPC_FILE_CLR = 7'h03;
	localparam logic [6:0]  OPC_WORK_CLR = 7'h02;
	localparam logic [13:0] OPC_WDOG_CLR = 14'h0064;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [7:0]  WORK_RST      = 8'h00;
	localparam logic        Z_RST         = 1'b0;
	localparam logic        FLAG_N_RST    = 1'b1;
	localparam logic [7:0]  PRE_LIMIT_RST = 8'h0f;
	localparam logic [13:0] INSTR_RST     = 14'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [3:0] {
		OP_NONE = 4'b0001,
		OP_FILE = 4'b0010,
		OP_WORK = 4'b0100,
		OP_WDOG = 4'b1000
	} op_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_EXEC = 3'b100
	} state_e;

	function automatic op_e decode_op(input logic [13:0] w);
		if (w[13:7] == OPC_FILE_CLR)
			return OP_FILE;
		if (w[13:7] == OPC_WORK_CLR)
			return OP_WORK;
		if (w == OPC_WDOG_CLR)
			return OP_WDOG;
		return OP_NONE;
	endfunction : decode_op

endpackage : clr_exec_pkg

// ===== hdl/phase_gen.sv
`timescale 1ns/1ps
`default_nettype none

module phase_gen #(
	parameter int unsigned PHASES = clr_exec_pkg::PHASE_COUNT
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              srst,
	// One-hot phase, bit 0 is the first phase
	output logic [PHASES-1:0]      phase
);

	if (PHASES < 2) begin : g_chk
		$error("phase_gen needs at least two phases");
	end

	always_ff @(posedge mclk) begin
		if (srst)
			phase <= PHASES'(1);
		else
			phase <= {phase[PHASES-2:0], phase[PHASES-1]};
	end

endmodule : phase_gen

`default_nettype wire

// ===== hdl/watchdog_unit.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_unit #(
	parameter int unsigned CNT_W = clr_exec_pkg::WDOG_CNT_W,
	parameter int unsigned PRE_W = clr_exec_pkg::WDOG_PRE_W
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              srst,
	// Control
	input  wire logic              tick,
	input  wire logic              clear,
	input  wire logic [PRE_W-1:0]  prescale_limit,
	// State
	output logic [CNT_W-1:0]       count,
	output logic [PRE_W-1:0]       prescale,
	output logic                   expired
);

	if (CNT_W < 1 || PRE_W < 1) begin : g_chk
		$error("watchdog_unit widths must be at least one");
	end

	// Clear outranks a coincident tick
	always_ff @(posedge mclk) begin
		if (srst || clear) begin
			count    <= '0; // RULE3
			prescale <= '0; // RULE4
			expired  <= 1'b0;
		end else if (tick) begin
			// Lowered limit takes effect at once, no long wrap
			if (prescale >= prescale_limit) begin
				prescale <= '0;
				count    <= count + CNT_W'(1);
				expired  <= &count;
			end else begin
				prescale <= prescale + PRE_W'(1);
				expired  <= 1'b0;
			end
		end else begin
			expired <= 1'b0;
		end
	end

endmodule : watchdog_unit

`default_nettype wire

// ===== hdl/clear_instruction_exec.sv
// Behaviour
// [RULE1] A file-register clear writes zero to the register picked by the 7-bit operand and sets zero.
// [RULE2] A working-register clear loads zero into the working register and sets zero.
// [RULE3] A watchdog clear resets the watchdog counter to zero.
// [RULE4] A watchdog clear resets the watchdog prescaler to zero together with the counter.
// [RULE5] A watchdog clear sets the time-out and power-down flags to one and leaves other status alone.
// [RULE6] Each clear is one word and one instruction cycle, its effect landing in the fourth phase.
`timescale 1ns/1ps
`default_nettype none

module clear_instruction_exec #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              srst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Core events
	input  wire logic              sleep_req,
	// Watchdog
	output logic                   wdt_expired
);

	if (ADDR_W < 8) begin : g_chk
		$error("clear_instruction_exec needs an address of at least eight bits");
	end

	// Status fields share one bus word
	if (clr_exec_pkg::INSTR_W > clr_exec_pkg::BUSY_BIT
			|| clr_exec_pkg::UNSUP_BIT > 31) begin : g_chk_fields
		$error("clear_instruction_exec status fields do not fit the bus word");
	end

	if (clr_exec_pkg::WDOG_PRE_LSB < clr_exec_pkg::WDOG_CNT_W
			|| clr_exec_pkg::WDOG_PRE_LSB + clr_exec_pkg::WDOG_PRE_W > 32) begin : g_chk_wdog
		$error("clear_instruction_exec watchdog fields do not fit the bus word");
	end

	// Operand must reach every file register
	if (clr_exec_pkg::FILE_DEPTH != 2 ** clr_exec_pkg::FILE_ADDR_W) begin : g_chk_depth
		$error("clear_instruction_exec file depth does not match the operand width");
	end

	// Effects land in the fourth phase
	if (clr_exec_pkg::PHASE_COUNT != 4) begin : g_chk_phase
		$error("clear_instruction_exec needs four phases per instruction cycle");
	end

	localparam int unsigned DW = clr_exec_pkg::DATA_W;
	localparam int unsigned AW = clr_exec_pkg::FILE_ADDR_W;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return a == ADDR_W'(off);
	endfunction : hit

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return hit(a, clr_exec_pkg::ADDR_INSTR) || hit(a, clr_exec_pkg::ADDR_WORK)
			|| hit(a, clr_exec_pkg::ADDR_STATUS) || hit(a, clr_exec_pkg::ADDR_FILE_ADDR)
			|| hit(a, clr_exec_pkg::ADDR_FILE_DATA) || hit(a, clr_exec_pkg::ADDR_WDOG)
			|| hit(a, clr_exec_pkg::ADDR_WDOG_CFG);
	endfunction : mapped

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [clr_exec_pkg::PHASE_COUNT-1:0] phase;
	clr_exec_pkg::state_e                 state_q;
	clr_exec_pkg::op_e                    op_q;
	logic [clr_exec_pkg::INSTR_W-1:0]     instr_q;
	logic                                 unsup_q;
	logic [DW-1:0]                        work_q;
	logic                                 z_q;
	logic                                 timeout_flag_n;
	logic                                 powerdown_flag_n;
	logic [AW-1:0]                        file_addr_q;
	logic [DW-1:0]                        file_mem [clr_exec_pkg::FILE_DEPTH];
	logic [clr_exec_pkg::WDOG_PRE_W-1:0]  pre_limit_q;
	logic [clr_exec_pkg::WDOG_CNT_W-1:0]  watchdog_counter;
	logic [clr_exec_pkg::WDOG_PRE_W-1:0]  wdog_prescale;
	logic                                 wdog_expired;
	logic                                 access;
	logic                                 commit_wr;
	logic                                 busy;
	logic                                 q1;
	logic                                 q4;
	logic                                 exec_q4;
	logic                                 file_reg_clear_op;
	logic                                 work_reg_clear_op;
	logic                                 watchdog_clear_op;
	logic                                 wr_err;
	logic [31:0]                          rd_data;

	////////////////////////////////////////////////////////////////////////////
	// Instruction phases
	phase_gen #(
		.PHASES (clr_exec_pkg::PHASE_COUNT)
	) u_phase (
		.mclk  (mclk),
		.srst  (srst),
		.phase (phase)
	);

	assign q1      = phase[0];
	assign q4      = phase[clr_exec_pkg::PHASE_COUNT-1];
	assign busy    = state_q != clr_exec_pkg::ST_IDLE;
	assign exec_q4 = (state_q == clr_exec_pkg::ST_EXEC) && q4; // RULE6

	assign file_reg_clear_op = exec_q4 && (op_q == clr_exec_pkg::OP_FILE);
	assign work_reg_clear_op = exec_q4 && (op_q == clr_exec_pkg::OP_WORK);
	assign watchdog_clear_op = exec_q4 && (op_q == clr_exec_pkg::OP_WDOG);

	////////////////////////////////////////////////////////////////////////////
	// APB handshake
	assign access    = psel && penable;
	assign commit_wr = access && pready && pwrite && !pslverr;

	always_comb begin
		wr_err = !mapped(paddr);
		if (pwrite && hit(paddr, clr_exec_pkg::ADDR_WDOG))
			wr_err = 1'b1;
		if (pwrite && hit(paddr, clr_exec_pkg::ADDR_INSTR) && busy)
			wr_err = 1'b1;
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit(paddr, clr_exec_pkg::ADDR_INSTR)) begin
			rd_data[clr_exec_pkg::INSTR_W-1:0] = instr_q;
			rd_data[clr_exec_pkg::BUSY_BIT]    = busy;
			rd_data[clr_exec_pkg::UNSUP_BIT]   = unsup_q;
		end
		if (hit(paddr, clr_exec_pkg::ADDR_WORK))
			rd_data[DW-1:0] = work_q;
		if (hit(paddr, clr_exec_pkg::ADDR_STATUS)) begin
			rd_data[clr_exec_pkg::STAT_Z_BIT]  = z_q;
			rd_data[clr_exec_pkg::STAT_PD_BIT] = powerdown_flag_n;
			rd_data[clr_exec_pkg::STAT_TO_BIT] = timeout_flag_n;
		end
		if (hit(paddr, clr_exec_pkg::ADDR_FILE_ADDR))
			rd_data[AW-1:0] = file_addr_q;
		if (hit(paddr, clr_exec_pkg::ADDR_FILE_DATA))
			rd_data[DW-1:0] = file_mem[file_addr_q];
		if (hit(paddr, clr_exec_pkg::ADDR_WDOG)) begin
			rd_data[clr_exec_pkg::WDOG_CNT_W-1:0] = watchdog_counter;
			rd_data[clr_exec_pkg::WDOG_PRE_LSB +: clr_exec_pkg::WDOG_PRE_W] = wdog_prescale;
		end
		if (hit(paddr, clr_exec_pkg::ADDR_WDOG_CFG))
			rd_data[clr_exec_pkg::WDOG_PRE_W-1:0] = pre_limit_q;
	end

	// One wait state: answer in the second access cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (access && !pready) begin
			pready  <= 1'b1;
			pslverr <= wr_err;
			prdata  <= pwrite ? 32'h0000_0000 : rd_data;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Instruction sequencing
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= clr_exec_pkg::ST_IDLE;
			op_q    <= clr_exec_pkg::OP_NONE;
			instr_q <= clr_exec_pkg::INSTR_RST;
		end else begin
			unique case (state_q)
				clr_exec_pkg::ST_IDLE: begin
					if (commit_wr && hit(paddr, clr_exec_pkg::ADDR_INSTR)) begin
						instr_q <= pwdata[clr_exec_pkg::INSTR_W-1:0];
						state_q <= clr_exec_pkg::ST_WAIT;
					end
				end
				clr_exec_pkg::ST_WAIT: begin
					// Decode in the first phase
					if (q1) begin
						op_q    <= clr_exec_pkg::decode_op(instr_q); // RULE6
						state_q <= clr_exec_pkg::ST_EXEC;
					end
				end
				clr_exec_pkg::ST_EXEC: begin
					if (q4)
						state_q <= clr_exec_pkg::ST_IDLE; // RULE6
				end
			endcase
		end
	end

	// Word that is no clear is retired as a no-operation
	always_ff @(posedge mclk) begin
		if (srst)
			unsup_q <= 1'b0;
		else if (exec_q4)
			unsup_q <= op_q == clr_exec_pkg::OP_NONE;
	end

	////////////////////////////////////////////////////////////////////////////
	// Working register
	always_ff @(posedge mclk) begin
		if (srst)
			work_q <= clr_exec_pkg::WORK_RST;
		else if (work_reg_clear_op)
			work_q <= '0; // RULE2
		else if (commit_wr && hit(paddr, clr_exec_pkg::ADDR_WORK))
			work_q <= pwdata[DW-1:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flags
	always_ff @(posedge mclk) begin
		if (srst)
			z_q <= clr_exec_pkg::Z_RST;
		else if (file_reg_clear_op || work_reg_clear_op)
			z_q <= 1'b1; // RULE1 RULE2
		else if (commit_wr && hit(paddr, clr_exec_pkg::ADDR_STATUS))
			z_q <= pwdata[clr_exec_pkg::STAT_Z_BIT];
	end

	// Set by a watchdog clear wins over a coincident expiry
	always_ff @(posedge mclk) begin
		if (srst)
			timeout_flag_n <= clr_exec_pkg::FLAG_N_RST;
		else if (watchdog_clear_op)
			timeout_flag_n <= 1'b1; // RULE5
		else if (wdog_expired)
			timeout_flag_n <= 1'b0;
	end

	// Set by a watchdog clear wins over a coincident sleep
	always_ff @(posedge mclk) begin
		if (srst)
			powerdown_flag_n <= clr_exec_pkg::FLAG_N_RST;
		else if (watchdog_clear_op)
			powerdown_flag_n <= 1'b1; // RULE5
		else if (sleep_req)
			powerdown_flag_n <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// File registers
	always_ff @(posedge mclk) begin
		if (srst)
			file_addr_q <= '0;
		else if (commit_wr && hit(paddr, clr_exec_pkg::ADDR_FILE_ADDR))
			file_addr_q <= pwdata[AW-1:0];
	end

	// File-register clear outranks a bus write in the same cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < clr_exec_pkg::FILE_DEPTH; i++)
				file_mem[i] <= '0;
		end else if (file_reg_clear_op) begin
			file_mem[instr_q[AW-1:0]] <= '0; // RULE1
		end else if (commit_wr && hit(paddr, clr_exec_pkg::ADDR_FILE_DATA)) begin
			file_mem[file_addr_q] <= pwdata[DW-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Watchdog
	always_ff @(posedge mclk) begin
		if (srst)
			pre_limit_q <= clr_exec_pkg::PRE_LIMIT_RST;
		else if (commit_wr && hit(paddr, clr_exec_pkg::ADDR_WDOG_CFG))
			pre_limit_q <= pwdata[clr_exec_pkg::WDOG_PRE_W-1:0];
	end

	// Ticks once per instruction cycle; the counter steps once every pre_limit_q + 1 ticks
	watchdog_unit #(
		.CNT_W (clr_exec_pkg::WDOG_CNT_W),
		.PRE_W (clr_exec_pkg::WDOG_PRE_W)
	) u_wdog (
		.mclk           (mclk),
		.srst           (srst),
		.tick           (q4),
		.clear          (watchdog_clear_op), // RULE3 RULE4
		.prescale_limit (pre_limit_q),
		.count          (watchdog_counter),
		.prescale       (wdog_prescale),
		.expired        (wdog_expired)
	);

	always_ff @(posedge mclk) begin
		if (srst)
			wdt_expired <= 1'b0;
		else
			wdt_expired <= wdog_expired;
	end

endmodule : clear_instruction_exec

`default_nettype wire

// ===== testbench/clr_exec_props.sv
`timescale 1ns/1ps
`default_nettype none

module clr_exec_props #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              srst,
	// APB
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr,
	// Core events
	input  wire logic              sleep_req,
	input  wire logic              wdt_expired
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	logic        wr;
	logic        rd;
	logic        done_ok;
	logic [5:0]  cnt_q;
	logic [13:0] word_q;
	logic        clean_q;
	logic [6:0]  fa_q;

	assign wr = psel && penable && pready && !pslverr && pwrite;
	assign rd = psel && penable && pready && !pslverr && !pwrite;
	assign done_ok = cnt_q >= 6'd9 && cnt_q <= 6'd40 && clean_q;

	////////////////////////////////////////////////////////////////////////////
	// Cycles since the last accepted instruction word
	always_ff @(posedge mclk) begin
		if (srst)
			cnt_q <= 6'h3f;
		else if (wr && paddr == clr_exec_pkg::ADDR_INSTR)
			cnt_q <= 6'h00;
		else if (cnt_q != 6'h3f)
			cnt_q <= cnt_q + 6'h01;
	end

	always_ff @(posedge mclk) begin
		if (srst)
			word_q <= 14'h0000;
		else if (wr && paddr == clr_exec_pkg::ADDR_INSTR)
			word_q <= pwdata[13:0];
	end

	// No disturbing event since the instruction
	always_ff @(posedge mclk) begin
		if (srst)
			clean_q <= 1'b0;
		else if (wr && paddr == clr_exec_pkg::ADDR_INSTR)
			clean_q <= 1'b1;
		else if ((wr && paddr != clr_exec_pkg::ADDR_FILE_ADDR) || sleep_req || wdt_expired)
			clean_q <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (srst)
			fa_q <= 7'h00;
		else if (wr && paddr == clr_exec_pkg::ADDR_FILE_ADDR)
			fa_q <= pwdata[6:0];
	end

	////////////////////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		penable && !pready ##1 pready;
	endsequence
	property p_one_wait;
		s_setup |=> s_answer;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("answer not after one wait state");

	property p_busy_window;
		rd && paddr == clr_exec_pkg::ADDR_INSTR && !(cnt_q inside {[5:7]})
			|-> prdata[16] == (cnt_q <= 6'd4);
	endproperty
	a_busy_window: assert property (p_busy_window) else $error("busy outside window");

	property p_file_clear;
		rd && paddr == clr_exec_pkg::ADDR_FILE_DATA && done_ok && fa_q == word_q[6:0]
			&& word_q[13:7] == clr_exec_pkg::OPC_FILE_CLR |-> prdata[7:0] == 8'h00;
	endproperty
	a_file_clear: assert property (p_file_clear) else $error("file register not zero");

	property p_work_clear;
		rd && paddr == clr_exec_pkg::ADDR_WORK && done_ok
			&& word_q[13:7] == clr_exec_pkg::OPC_WORK_CLR |-> prdata[7:0] == 8'h00;
	endproperty
	a_work_clear: assert property (p_work_clear) else $error("working reg not zero");

	property p_zero_set;
		rd && paddr == clr_exec_pkg::ADDR_STATUS && done_ok && word_q[13:8] == 6'h01
			|-> prdata[2];
	endproperty
	a_zero_set: assert property (p_zero_set) else $error("zero flag not set");

	property p_wdog_count;
		rd && paddr == clr_exec_pkg::ADDR_WDOG && done_ok
			&& word_q == clr_exec_pkg::OPC_WDOG_CLR |-> prdata[7:0] <= 8'd10;
	endproperty
	a_wdog_count: assert property (p_wdog_count) else $error("counter not cleared");

	property p_wdog_pre;
		rd && paddr == clr_exec_pkg::ADDR_WDOG && done_ok
			&& word_q == clr_exec_pkg::OPC_WDOG_CLR |-> prdata[15:8] <= 8'd10;
	endproperty
	a_wdog_pre: assert property (p_wdog_pre) else $error("prescaler not cleared");

	property p_flags_set;
		rd && paddr == clr_exec_pkg::ADDR_STATUS && done_ok
			&& word_q == clr_exec_pkg::OPC_WDOG_CLR |-> prdata[4:3] == 2'b11;
	endproperty
	a_flags_set: assert property (p_flags_set) else $error("status flags not set");
endmodule : clr_exec_props

bind clear_instruction_exec clr_exec_props #(.ADDR_W(ADDR_W)) props (
	.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sleep_req(sleep_req), .wdt_expired(wdt_expired));

`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sleep_req = 1'b0;
	logic        wdt_expired;
	logic [31:0] rdv;
	logic        errv;
	logic [6:0]  idx [3] = '{7'h00, 7'h7f, 7'h2a};
	int          failures = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          n;

	always #50 mclk = ~mclk;

	clear_instruction_exec #(.ADDR_W(8)) dut (
		.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_req(sleep_req), .wdt_expired(wdt_expired));

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask : rd

	// Issue a word; unsupported words also try a refused second word
	task automatic exec(input logic [13:0] w, input logic other);
		int k;
		k = 0;
		wr(clr_exec_pkg::ADDR_INSTR, {18'h0, w});
		check(errv, 1'b0);
		if (other) begin
			wr(clr_exec_pkg::ADDR_INSTR, 32'h64);
			check(errv, 1'b1);
		end else begin
			rd(clr_exec_pkg::ADDR_INSTR);
			check(rdv[16], 1'b1);
		end
		do begin
			rd(clr_exec_pkg::ADDR_INSTR);
			k++;
		end while (rdv[16] === 1'b1 && k < 8);
		check(k <= 2, 1'b1);
		check(rdv, {14'h0, other, 3'h0, w});
	endtask : exec

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			$display("unexpected at %0t: run hung", $time);
			complete_run();
		end
	end

	initial begin
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		rd(clr_exec_pkg::ADDR_STATUS);
		check(rdv, 32'h18);
		rd(clr_exec_pkg::ADDR_WDOG_CFG);
		check(rdv, 32'h0f);
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			wr(clr_exec_pkg::ADDR_WORK, 32'h5a);
			wr(clr_exec_pkg::ADDR_STATUS, 32'h0);
			exec({clr_exec_pkg::OPC_WORK_CLR, (i == 0) ? 7'h00 : 7'h7f}, 1'b0);
			rd(clr_exec_pkg::ADDR_WORK);
			check(rdv, 32'h0);
			rd(clr_exec_pkg::ADDR_STATUS);
			check(rdv, 32'h1c);
		end
		$display("test working clear done");
		for (int k = 0; k < 3; k++) begin
			wr(clr_exec_pkg::ADDR_FILE_ADDR, {25'h0, idx[k] ^ 7'h01});
			wr(clr_exec_pkg::ADDR_FILE_DATA, 32'ha5);
			wr(clr_exec_pkg::ADDR_FILE_ADDR, {25'h0, idx[k]});
			wr(clr_exec_pkg::ADDR_FILE_DATA, 32'h5a);
			wr(clr_exec_pkg::ADDR_STATUS, 32'h0);
			exec({clr_exec_pkg::OPC_FILE_CLR, idx[k]}, 1'b0);
			rd(clr_exec_pkg::ADDR_FILE_DATA);
			check(rdv, 32'h0);
			rd(clr_exec_pkg::ADDR_STATUS);
			check(rdv, 32'h1c);
			wr(clr_exec_pkg::ADDR_FILE_ADDR, {25'h0, idx[k] ^ 7'h01});
			rd(clr_exec_pkg::ADDR_FILE_DATA);
			check(rdv, 32'ha5);
		end
		$display("test file clear done");
		wr(clr_exec_pkg::ADDR_WDOG_CFG, 32'h0);
		n = 0;
		while (wdt_expired !== 1'b1 && n < 1500) begin
			@(posedge mclk);
			n++;
		end
		check(n < 1500, 1'b1);
		sleep_req <= 1'b1;
		@(posedge mclk);
		sleep_req <= 1'b0;
		rd(clr_exec_pkg::ADDR_STATUS);
		check(rdv, 32'h04);
		wr(clr_exec_pkg::ADDR_WDOG_CFG, 32'h0f);
		exec(clr_exec_pkg::OPC_WDOG_CLR, 1'b0);
		rd(clr_exec_pkg::ADDR_WDOG);
		check(rdv[7:0], 8'h00);
		check(rdv[15:10], 6'h00);
		rd(clr_exec_pkg::ADDR_STATUS);
		check(rdv, 32'h1c);
		$display("test watchdog clear done");
		wr(clr_exec_pkg::ADDR_WORK, 32'h33);
		exec(14'h0080, 1'b1);
		rd(clr_exec_pkg::ADDR_WORK);
		check(rdv, 32'h33);
		wr(clr_exec_pkg::ADDR_WDOG, 32'h0);
		check(errv, 1'b1);
		rd(8'h1c);
		check(errv, 1'b1);
		check(rdv, 32'h0);
		$display("test refusals done");
		complete_run();
	end
endmodule : tb

`default_nettype wire
